// *** verilog/cal_pattern_pkg.sv ***
/*
  Shared constants and carriers for the calibration pattern read-out block:
  register map, mode register field positions, pattern and burst figures.
  Assumes nothing of its surroundings.
*/
package cal_pattern_pkg;
  // Wishbone byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  // Control register fields and reset values
  localparam int CTRL_X16_BIT = 0;
  localparam int CTRL_REPL_BIT = 1;
  localparam int CTRL_LAT_LSB = 4;
  localparam logic CTRL_X16_RESET = 1'h0;
  localparam logic CTRL_REPL_RESET = 1'h1;
  localparam logic [2:0] CTRL_LAT_RESET = 3'h4;
  // Status register fields
  localparam int ST_MODE_BIT = 0;
  localparam int ST_LOC_LSB = 1;
  localparam int ST_WL_BIT = 3;
  localparam int ST_RTTWR_LSB = 4;
  localparam int ST_OTF_BIT = 6;
  localparam int ST_ILLEGAL_BIT = 7;
  // Mode register selection on bank address
  localparam logic [2:0] MR_SEL_FIRST = 3'h0;
  localparam logic [2:0] MR_SEL_NOMINAL = 3'h1;
  localparam logic [2:0] MR_SEL_SECOND = 3'h2;
  localparam logic [2:0] MR_SEL_THIRD = 3'h3;
  // Mode register field positions
  localparam int MR0_BL_LSB = 0;
  localparam int MR1_NOM_B0 = 2;
  localparam int MR1_NOM_B1 = 6;
  localparam int MR1_WL_BIT = 7;
  localparam int MR1_NOM_B2 = 9;
  localparam int MR2_RTTWR_LSB = 9;
  localparam int MR3_LOC_LSB = 0;
  localparam int MR3_MODE_BIT = 2;
  // Column address fields of a read
  localparam int ADDR_NIBBLE_BIT = 2;
  localparam int ADDR_AP_BIT = 10;
  localparam int ADDR_BC_BIT = 12;
  // Burst length modes and figures
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  // Pattern location and content, beat 0 in the LSB
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'hAA;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } cmd_s;

  typedef struct packed {
    logic valid;
    logic pat;
    logic bc4;
    logic hi;
    logic [1:0] loc;
  } rd_req_s;

  typedef enum logic [2:0] {CMD_IDLE, CMD_MRS, CMD_READ, CMD_WRITE, CMD_OTHER} cmd_e;
endpackage

// *** verilog/pin_sync.sv ***
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes the pins are asynchronous to clk_i; only the second stage is read.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.meta = d_i;
      s_next.stable = s_reg.meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= {INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.stable;
endmodule
`default_nettype wire

// *** verilog/read_delay_line.sv ***
/*
  Fixed-depth shift line with a selectable tap, used to delay read requests.
  Assumes tap_i is held steady while requests are in flight.
*/
`timescale 1ns/100ps
`default_nettype none
module read_delay_line #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  input wire logic [$clog2(DEPTH)-1:0] tap_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } line_s;

  line_s s_reg;
  line_s s_next;

  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.stage = {s_reg.stage[DEPTH-2:0], d_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.stage[tap_i];
endmodule
`default_nettype wire

// *** verilog/sdram_calibration_pattern_readout.sv ***
/*
  Device-side command decoder, mode register store and read-out path with
  calibration pattern redirection; Wishbone classic slave for control/status.
  Assumes command pins asynchronous to clk_i, one data beat per clock, and an
  array that answers array_data_i combinationally for the requested beat.
*/
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module sdram_calibration_pattern_readout #(
  parameter int LAT_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reset_n_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] ba_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic array_rd_o,
  output logic array_wr_o,
  output logic array_precharge_o,
  output logic [2:0] array_ba_o,
  output logic [15:0] array_addr_o,
  output logic array_beat_o,
  output logic [2:0] array_beat_idx_o,
  input wire logic [15:0] array_data_i,
  output logic [2:0] rtt_nom_o,
  output logic [1:0] rtt_wr_o
);
  typedef struct packed {
    logic mode;
    logic [1:0] loc;
    logic [1:0] bl_mode;
    logic wl;
    logic [2:0] rtt_nom;
    logic [1:0] rtt_wr;
    logic illegal;
    logic [15:0] pat_count;
    logic x16;
    logic repl;
    logic [2:0] latency;
    logic arr_rd;
    logic arr_wr;
    logic arr_pre;
    logic [2:0] arr_ba;
    logic [15:0] arr_addr;
    logic b_pat;
    logic [1:0] b_loc;
    logic [2:0] beat;
    logic [3:0] left;
    logic [15:0] dq;
    logic dq_oe;
    logic [2:0] out_beat;
    logic out_pat;
    logic [1:0] out_loc;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s s_reg;
  state_s s_next;
  cal_pattern_pkg::cmd_s cmd;
  cal_pattern_pkg::cmd_e kind;
  cal_pattern_pkg::rd_req_s req;
  cal_pattern_pkg::rd_req_s line_q;
  logic dev_rst_n;
  logic mrs_third;
  logic ill_set;
  logic bc4;
  logic go;
  logic bp;
  logic [1:0] bl;
  logic [2:0] bb;
  logic [3:0] left;
  logic [31:0] status_word;

  function automatic cal_pattern_pkg::cmd_e decode_cmd(input cal_pattern_pkg::cmd_s c);
    cal_pattern_pkg::cmd_e k;
    k = cal_pattern_pkg::CMD_OTHER;
    if (!c.cke) begin
      k = cal_pattern_pkg::CMD_OTHER;
    end else if (c.cs_n) begin
      k = cal_pattern_pkg::CMD_IDLE;
    end else begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'h0: k = cal_pattern_pkg::CMD_MRS;
        3'h5: k = cal_pattern_pkg::CMD_READ;
        3'h4: k = cal_pattern_pkg::CMD_WRITE;
        3'h7: k = cal_pattern_pkg::CMD_IDLE;
        default: k = cal_pattern_pkg::CMD_OTHER;
      endcase
    end
    return k;
  endfunction

  // Pattern bit of one beat; reserved locations read as zero
  function automatic logic pattern_bit(input logic [1:0] loc, input logic [2:0] beat);
    return (loc == cal_pattern_pkg::LOC_PATTERN) ? cal_pattern_pkg::CAL_PATTERN[beat] : 1'h0;
  endfunction

  function automatic logic [15:0] lane_word(input logic b, input logic x16, input logic repl);
    logic [7:0] lane;
    lane = repl ? {8{b}} : {7'h00, b};
    return x16 ? {lane, lane} : {8'h00, lane};
  endfunction

  pin_sync #(
    .WIDTH($bits(cal_pattern_pkg::cmd_s) + 1),
    .INIT('1)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({reset_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i}),
    .q_o({dev_rst_n, cmd})
  );

  // One delay line for both pattern and array reads
  read_delay_line #(
    .WIDTH($bits(cal_pattern_pkg::rd_req_s)),
    .DEPTH(LAT_DEPTH)
  ) u_read_delay_line (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(req),
    .tap_i(s_reg.latency),
    .q_o(line_q)
  );

  assign kind = decode_cmd(cmd);
  assign mrs_third = (kind == cal_pattern_pkg::CMD_MRS) && (cmd.ba == cal_pattern_pkg::MR_SEL_THIRD);
  // Refused command in pattern mode; beats a same-cycle clear
  assign ill_set = dev_rst_n && s_reg.mode
                   && !(kind == cal_pattern_pkg::CMD_READ || kind == cal_pattern_pkg::CMD_IDLE || mrs_third);

  // Chop per command only with on-the-fly length
  always_comb begin
    if (s_reg.bl_mode == cal_pattern_pkg::BL_OTF) begin
      bc4 = !cmd.addr[cal_pattern_pkg::ADDR_BC_BIT];
    end else begin
      bc4 = (s_reg.bl_mode == cal_pattern_pkg::BL_FIXED4);
    end
  end

  // Nibble select only for chopped reads
  always_comb begin
    req = '0;
    req.valid = dev_rst_n && (kind == cal_pattern_pkg::CMD_READ);
    req.pat = s_reg.mode;
    req.bc4 = bc4;
    req.hi = bc4 && cmd.addr[cal_pattern_pkg::ADDR_NIBBLE_BIT];
    req.loc = s_reg.loc;
  end

  always_comb begin
    status_word = '0;
    status_word[cal_pattern_pkg::ST_MODE_BIT] = s_reg.mode;
    status_word[cal_pattern_pkg::ST_LOC_LSB +: 2] = s_reg.loc;
    status_word[cal_pattern_pkg::ST_WL_BIT] = s_reg.wl;
    status_word[cal_pattern_pkg::ST_RTTWR_LSB +: 2] = rtt_wr_o;
    status_word[cal_pattern_pkg::ST_OTF_BIT] = (s_reg.bl_mode == cal_pattern_pkg::BL_OTF);
    status_word[cal_pattern_pkg::ST_ILLEGAL_BIT] = s_reg.illegal;
  end

  // Burst source: a new request takes over at its first beat
  always_comb begin
    go = line_q.valid;
    if (go) begin
      bp = line_q.pat;
      bl = line_q.loc;
      bb = {line_q.hi, 2'h0};
      left = line_q.bc4 ? cal_pattern_pkg::BEATS_CHOP : cal_pattern_pkg::BEATS_FULL;
    end else begin
      bp = s_reg.b_pat;
      bl = s_reg.b_loc;
      bb = s_reg.beat;
      left = s_reg.left;
    end
  end

  always_comb begin
    s_next = s_reg;
    if (ce_i) begin
      s_next.arr_rd = 1'h0;
      s_next.arr_wr = 1'h0;
      s_next.arr_pre = 1'h0;
      s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
      if (!dev_rst_n) begin
        // Pin reset wins in any mode
        s_next.mode = 1'h0;
        s_next.loc = 2'h0;
        s_next.bl_mode = cal_pattern_pkg::BL_FIXED8;
        s_next.wl = 1'h0;
        s_next.rtt_nom = 3'h0;
        s_next.rtt_wr = 2'h0;
      end else if (s_reg.mode) begin
        case (kind)
          cal_pattern_pkg::CMD_READ: begin
            s_next.pat_count = s_reg.pat_count + 16'h0001;
          end
          cal_pattern_pkg::CMD_MRS: begin
            if (mrs_third) begin
              s_next.mode = cmd.addr[cal_pattern_pkg::MR3_MODE_BIT];
              s_next.loc = cmd.addr[cal_pattern_pkg::MR3_LOC_LSB +: 2];
            end else begin
              s_next.illegal = 1'h1;
            end
          end
          cal_pattern_pkg::CMD_IDLE: begin
            s_next.illegal = s_reg.illegal;
          end
          default: begin
            s_next.illegal = 1'h1;
          end
        endcase
      end else begin
        case (kind)
          cal_pattern_pkg::CMD_READ: begin
            s_next.arr_rd = 1'h1;
            s_next.arr_pre = cmd.addr[cal_pattern_pkg::ADDR_AP_BIT];
            s_next.arr_ba = cmd.ba;
            s_next.arr_addr = cmd.addr;
          end
          cal_pattern_pkg::CMD_WRITE: begin
            s_next.arr_wr = 1'h1;
            s_next.arr_pre = cmd.addr[cal_pattern_pkg::ADDR_AP_BIT];
            s_next.arr_ba = cmd.ba;
            s_next.arr_addr = cmd.addr;
          end
          cal_pattern_pkg::CMD_MRS: begin
            case (cmd.ba)
              cal_pattern_pkg::MR_SEL_FIRST: begin
                s_next.bl_mode = cmd.addr[cal_pattern_pkg::MR0_BL_LSB +: 2];
              end
              cal_pattern_pkg::MR_SEL_NOMINAL: begin
                s_next.wl = cmd.addr[cal_pattern_pkg::MR1_WL_BIT];
                s_next.rtt_nom = {cmd.addr[cal_pattern_pkg::MR1_NOM_B2], cmd.addr[cal_pattern_pkg::MR1_NOM_B1],
                                  cmd.addr[cal_pattern_pkg::MR1_NOM_B0]};
              end
              cal_pattern_pkg::MR_SEL_SECOND: begin
                s_next.rtt_wr = cmd.addr[cal_pattern_pkg::MR2_RTTWR_LSB +: 2];
              end
              cal_pattern_pkg::MR_SEL_THIRD: begin
                // Location kept only when the mode is switched on
                s_next.mode = cmd.addr[cal_pattern_pkg::MR3_MODE_BIT];
                if (cmd.addr[cal_pattern_pkg::MR3_MODE_BIT]) begin
                  s_next.loc = cmd.addr[cal_pattern_pkg::MR3_LOC_LSB +: 2];
                end
              end
              default: begin
                s_next.mode = s_reg.mode;
              end
            endcase
          end
          default: begin
            s_next.mode = s_reg.mode;
          end
        endcase
      end
      // Pattern reads never precharge
      s_next.dq_oe = (left != 4'h0);
      if (left != 4'h0) begin
        s_next.dq = bp ? lane_word(pattern_bit(bl, bb), s_reg.x16, s_reg.repl) : array_data_i;
        s_next.out_beat = bb;
        s_next.out_pat = bp;
        s_next.out_loc = bl;
        s_next.beat = bb + 3'h1;
        s_next.left = left - 4'h1;
        s_next.b_pat = bp;
        s_next.b_loc = bl;
      end
      if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
        s_next.rdata = 32'h0000_0000;
        case (wb_adr_i)
          cal_pattern_pkg::REG_CTRL: begin
            s_next.rdata[cal_pattern_pkg::CTRL_X16_BIT] = s_reg.x16;
            s_next.rdata[cal_pattern_pkg::CTRL_REPL_BIT] = s_reg.repl;
            s_next.rdata[cal_pattern_pkg::CTRL_LAT_LSB +: 3] = s_reg.latency;
            if (wb_we_i && wb_sel_i[0]) begin
              s_next.x16 = wb_dat_i[cal_pattern_pkg::CTRL_X16_BIT];
              s_next.repl = wb_dat_i[cal_pattern_pkg::CTRL_REPL_BIT];
              s_next.latency = wb_dat_i[cal_pattern_pkg::CTRL_LAT_LSB +: 3];
            end
          end
          cal_pattern_pkg::REG_STATUS: begin
            s_next.rdata = status_word;
            // Write-one clear; a new illegal command in this cycle still sets
            if (wb_we_i && wb_sel_i[0] && wb_dat_i[cal_pattern_pkg::ST_ILLEGAL_BIT] && !ill_set) begin
              s_next.illegal = 1'h0;
            end
          end
          cal_pattern_pkg::REG_COUNT: begin
            s_next.rdata = {16'h0000, s_reg.pat_count};
          end
          default: begin
            s_next.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.x16 <= cal_pattern_pkg::CTRL_X16_RESET;
      s_reg.repl <= cal_pattern_pkg::CTRL_REPL_RESET;
      s_reg.latency <= cal_pattern_pkg::CTRL_LAT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign dq_o = s_reg.dq;
  assign dq_oe_o = s_reg.dq_oe;
  assign array_rd_o = s_reg.arr_rd;
  assign array_wr_o = s_reg.arr_wr;
  assign array_precharge_o = s_reg.arr_pre;
  assign array_ba_o = s_reg.arr_ba;
  assign array_addr_o = s_reg.arr_addr;
  assign array_beat_o = ce_i && (left != 4'h0) && !bp;
  assign array_beat_idx_o = bb;
  assign rtt_nom_o = s_reg.rtt_nom;
  assign rtt_wr_o = s_reg.wl ? 2'h0 : s_reg.rtt_wr;

  a_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && dev_rst_n && mrs_third && cmd.addr[cal_pattern_pkg::MR3_MODE_BIT]) |=> s_reg.mode)
    else $error("pattern mode not entered");
  a_mode_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && mrs_third && !cmd.addr[cal_pattern_pkg::MR3_MODE_BIT]) |=> !s_reg.mode)
    else $error("pattern mode not left");
  a_pin_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !dev_rst_n) |=> (!s_reg.mode && s_reg.loc == 2'h0))
    else $error("pin reset ignored in pattern mode");
  a_no_array_access: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && dev_rst_n && s_reg.mode && kind == cal_pattern_pkg::CMD_READ) |=> !array_rd_o && !array_precharge_o)
    else $error("pattern read reached the array");
  a_array_read_passes: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && dev_rst_n && !s_reg.mode && kind == cal_pattern_pkg::CMD_READ) |=> array_rd_o && array_addr_o == $past(cmd.addr))
    else $error("array read lost");
  a_pattern_beat_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (dq_oe_o && s_reg.out_pat && s_reg.out_loc == cal_pattern_pkg::LOC_PATTERN) |-> dq_o[0] == s_reg.out_beat[0])
    else $error("pattern beat bit wrong");
  a_x8_lane_fill: assert property (@(posedge clk_i) disable iff (rst_i)
    (dq_oe_o && s_reg.out_pat && !s_reg.x16) |-> (dq_o[15:8] == 8'h00 && (dq_o[7:1] == (s_reg.repl ? {7{dq_o[0]}} : 7'h00))))
    else $error("x8 upper bits wrong");
  a_x16_lane_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (dq_oe_o && s_reg.out_pat && s_reg.x16) |-> dq_o[15:8] == dq_o[7:0])
    else $error("x16 lanes differ");
  a_chop_high_nibble: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && line_q.valid && line_q.bc4 && line_q.hi) |=> (dq_oe_o && s_reg.out_beat == 3'h4 && s_reg.left == 4'h3))
    else $error("chopped burst did not start at beat 4");
  a_full_burst_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && line_q.valid && !line_q.bc4) |=> (dq_oe_o && s_reg.out_beat == 3'h0 && s_reg.left == 4'h7))
    else $error("full burst did not start at beat 0");
  a_leveling_no_dyn: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.wl |-> rtt_wr_o == 2'h0)
    else $error("dynamic termination during leveling");
endmodule
`default_nettype wire

// *** tb/ddr_ctrl_model.sv ***
/*
  Behavioural memory controller: drives command, bank and address pins.
  Assumes the caller spaces reads as the burst length needs.
*/
`timescale 1ns/100ps
`default_nettype none
module ddr_ctrl_model (
  input wire logic clk_i,
  output var cal_pattern_pkg::cmd_s cmd_o
);
  initial cmd_o = {1'b1, 4'hF, 3'h0, 16'h0000};
  // One command cycle, then deselect with lines toggled
  task automatic send(input logic [3:0] str_n, input logic [2:0] ba, input logic [15:0] a);
    @(posedge clk_i);
    cmd_o <= {1'b1, str_n, ba, a};
    @(posedge clk_i);
    cmd_o <= {1'b1, 1'b1, ~str_n[2:0], ~ba, ~a};
  endtask
  // No activate task of its own, loop taken as locked
  task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
    send(4'h0, ba, a & (ba == cal_pattern_pkg::MR_SEL_THIRD ? 16'h0007 : 16'hFFFF));
  endtask
  // Column bits 1:0 low, bank 0 only
  task automatic rd(input logic [15:0] a);
    send(4'b0101, 3'h0, a & 16'hFFFC);
  endtask
endmodule
`default_nettype wire

// *** tb/sdram_calibration_pattern_readout_tb.sv ***
/*
  Self-checking bench: pattern and array reads, termination, status.
  Assumes the controller model and the design package.
*/
`timescale 1ns/100ps
`default_nettype none
module sdram_calibration_pattern_readout_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, e;
  logic wb_ack_o, dq_oe_o, array_rd_o, array_precharge_o;
  logic reset_n_i = 1'b1;
  logic [15:0] dq_o, array_data_i;
  logic [15:0] arr [8];
  logic [15:0] ra [3] = '{16'h1400, 16'h0000, 16'h0004};
  logic [2:0] array_beat_idx_o, rtt_nom_o;
  logic [1:0] rtt_wr_o;
  logic [31:0] expq [$];
  int n_errors = 0, cmp_count = 0, n_ard = 0, n_apre = 0;
  cal_pattern_pkg::cmd_s cmd;
  always #20 clk_i = ~clk_i;
  assign array_data_i = arr[array_beat_idx_o];
  ddr_ctrl_model i_ctrl (.clk_i(clk_i), .cmd_o(cmd));
  sdram_calibration_pattern_readout #(.LAT_DEPTH(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_n_i(reset_n_i), .cke_i(cmd.cke),
    .cs_n_i(cmd.cs_n), .ras_n_i(cmd.ras_n), .cas_n_i(cmd.cas_n), .we_n_i(cmd.we_n), .ba_i(cmd.ba),
    .addr_i(cmd.addr), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .array_rd_o(array_rd_o), .array_wr_o(),
    .array_precharge_o(array_precharge_o), .array_ba_o(), .array_addr_o(), .array_beat_o(),
    .array_beat_idx_o(array_beat_idx_o), .array_data_i(array_data_i), .rtt_nom_o(rtt_nom_o),
    .rtt_wr_o(rtt_wr_o));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      check("wb ack", 0, 1);
      print_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Queue expected pattern beats, beat b from bit b
  task automatic pat(input int first, input int n, input logic x16, input logic repl);
    logic [7:0] lane;
    for (int b = first; b < first + n; b++) begin
      lane = cal_pattern_pkg::CAL_PATTERN[b] ? (repl ? 8'hFF : 8'h01) : 8'h00;
      expq.push_back({x16 ? 16'hFFFF : 16'h00FF, x16 ? {lane, lane} : {8'h00, lane}});
    end
  endtask
  always @(posedge clk_i) begin
    if (dq_oe_o === 1'b1) begin
      if (expq.size() == 0) check("extra beat", 1, 0);
      else begin
        e = expq.pop_front();
        check("dq beat", {16'h0, dq_o & e[31:16]}, {16'h0, e[15:0]});
      end
    end
    if (array_rd_o === 1'b1) n_ard++;
    if (array_precharge_o === 1'b1) n_apre++;
  end
  initial begin
    rd = $urandom(32'hF9D56E2B);
    foreach (arr[i]) arr[i] = 16'($urandom);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, cal_pattern_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h42);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("test registers done");
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_SECOND, 16'h0400);
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_NOMINAL, 16'h0244);
    repeat (4) @(posedge clk_i);
    check("rtt_wr", 32'(rtt_wr_o), 32'h2);
    check("rtt_nom", 32'(rtt_nom_o), 32'h7);
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_NOMINAL, 16'h0284);
    repeat (4) @(posedge clk_i);
    check("rtt_wr lvl", 32'(rtt_wr_o), 32'h0);
    check("rtt_nom lvl", 32'(rtt_nom_o), 32'h5);
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_NOMINAL, 16'h0000);
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_SECOND, 16'h0000);
    $display("test termination done");
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_FIRST, 16'h0001);
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_THIRD, 16'h0004);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, cal_pattern_pkg::REG_CTRL, 32'h40 | 32'(c));
      for (int r = 0; r < 3; r++) begin
        pat(r == 2 ? 4 : 0, r == 0 ? 8 : 4, c[0], c[1]);
        i_ctrl.rd(ra[r]);
        repeat (22) @(posedge clk_i);
      end
    end
    check("array rd in mode", 32'(n_ard + n_apre), 32'h0);
    wb(1'b0, cal_pattern_pkg::REG_STATUS, 32'h0);
    check("status mode", rd, 32'h41);
    wb(1'b0, cal_pattern_pkg::REG_COUNT, 32'h0);
    check("pattern read count", rd, 32'hC);
    $display("test pattern reads done");
    i_ctrl.send(4'b0011, 3'h0, 16'h0000);
    repeat (4) @(posedge clk_i);
    wb(1'b0, cal_pattern_pkg::REG_STATUS, 32'h0);
    check("status illegal", rd, 32'hC1);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, cal_pattern_pkg::REG_STATUS, 32'h0);
    check("status pin reset", rd & 32'h7F, 32'h0);
    $display("test refusal and reset done");
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_THIRD, 16'h0007);
    i_ctrl.mrs(cal_pattern_pkg::MR_SEL_THIRD, 16'h0003);
    foreach (arr[i]) expq.push_back({16'hFFFF, arr[i]});
    i_ctrl.rd(16'h0000);
    repeat (22) @(posedge clk_i);
    check("array rd count", 32'(n_ard), 32'h1);
    check("beats left", 32'(expq.size()), 32'h0);
    $display("test array read done");
    print_verdict();
  end
endmodule
`default_nettype wire
